/* common/dsps_pkg.sv */
package dsps_pkg;
    // phase codes, in running order
    typedef enum logic [1:0] {
        DSPS_PH_ZERO  = 2'b00,  // auto-zero
        DSPS_PH_SIG   = 2'b01,  // signal integrate
        DSPS_PH_REF_A = 2'b10,  // first reference integrate
        DSPS_PH_REF_B = 2'b11   // second reference integrate
    } dsps_phase_t;

    // counts
    localparam int DSPS_PHASES        = 4;      // phases per cycle
    localparam int DSPS_PHASE_LEN_DEF = 10000;  // clocks per phase
    localparam int DSPS_SW_NUM        = 6;      // analog switches

    // switch bit positions in the switch bus (switch n at bit n-1)
    localparam int DSPS_SW1 = 0;
    localparam int DSPS_SW2 = 1;
    localparam int DSPS_SW3 = 2;
    localparam int DSPS_SW4 = 3;
    localparam int DSPS_SW5 = 4;
    localparam int DSPS_SW6 = 5;

    // values after reset
    localparam logic [5:0] DSPS_SW_RST  = 6'h00;  // all switches open
    localparam logic       DSPS_POL_RST = 1'b1;   // positive polarity
endpackage : dsps_pkg

/* core/dsps_phase_timer.sv */
`timescale 1ns/10ps
// free-running clock counter that wraps at the phase length
module dsps_phase_timer #(
    parameter int PHASE_LEN = dsps_pkg::DSPS_PHASE_LEN_DEF,
    parameter int CNT_W     = $clog2(PHASE_LEN)
) (
    input  wire logic             i_ref_clk,  // converter clock
    input  wire logic             i_resetn,   // sync reset, active low
    output logic [CNT_W-1:0]      o_count,    // clocks into phase
    output logic                  o_wrap      // last clock of a phase
);
    import dsps_pkg::*;

    // a one-clock phase would leave no counter to wrap
    if (PHASE_LEN < 2 || (1 << CNT_W) < PHASE_LEN) begin : g_bad_len
        $error("dsps_phase_timer: bad phase length or width");
    end

    // last count of a phase, sized to the counter
    localparam logic [CNT_W-1:0] LAST = CNT_W'(PHASE_LEN - 1);

    logic [CNT_W-1:0] cnt_ff;     // current count
    logic [CNT_W-1:0] nxt_cnt;    // next count

    // never held: every phase, the signal phase above all, is exact
    always_comb begin
        if (cnt_ff == LAST) begin
            nxt_cnt = '0;
        end else begin
            nxt_cnt = cnt_ff + CNT_W'(1);
        end
    end

    // count register
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign o_count = cnt_ff;
    assign o_wrap  = (cnt_ff == LAST);
endmodule : dsps_phase_timer

/* core/dsps_sequencer.sv */
`timescale 1ns/10ps
// Functional notes
// - four equal phases: zero, signal, two reference
// - auto-zero closes switches one, two, three
// - signal phase opens 1-3, closes switch four
// - latch ramp sign at signal phase end
// - reference phases pick switch from polarity
// - positive polarity closes six, opens five
// - negative polarity closes five, opens six
// - result counts reference clocks until zero
// - reference window twice the signal length
// - zero crossing registered; it or window end stops count
// - result counter held first clock phase three
// - overload reads zero, via phase-one hold
// - no counting hold in signal phase
module dsps_sequencer #(
    parameter int PHASE_LEN = dsps_pkg::DSPS_PHASE_LEN_DEF,
    parameter int CNT_W     = $clog2(PHASE_LEN),
    parameter int RES_W     = CNT_W + 1
) (
    input  wire logic                    i_ref_clk,     // converter clock
    input  wire logic                    i_resetn,      // sync, active low
    input  wire logic                    i_comp,        // comparator, 1=above
    output logic [dsps_pkg::DSPS_SW_NUM-1:0] o_sw,      // switch n at bit n-1
    output dsps_pkg::dsps_phase_t        o_phase,       // current phase
    output logic                         o_polarity,    // 1 = positive input
    output logic [RES_W-1:0]             o_result,      // last reading
    output logic                         o_result_vld,  // one-cycle pulse
    output logic                         o_overrange    // last cycle overloaded
);
    import dsps_pkg::*;

    // refuse sizes the counters cannot hold, at elaboration
    if (PHASE_LEN < 2 || (1 << CNT_W) < PHASE_LEN ||
        (1 << RES_W) < 2 * PHASE_LEN) begin : g_bad_size
        $error("dsps_sequencer: bad phase length or widths");
    end

    // whole block state
    typedef struct packed {
        dsps_phase_t               phase;     // running phase
        logic                      comp;      // registered comparator
        logic                      pol;       // polarity flip-flop
        logic                      counting;  // result count running
        logic                      hold;      // one-clock count hold
        logic [RES_W-1:0]          cnt;       // result counter
        logic [RES_W-1:0]          result;    // latched reading
        logic                      vld;       // result pulse
        logic                      over;      // overload flag
        logic [DSPS_SW_NUM-1:0]    sw;        // switch drive
    } dsps_state_t;

    dsps_state_t st_ff;                // registered state
    dsps_state_t nxt_st;               // next state
    logic        wrap;                 // last clock of phase
    logic        crossed;              // registered zero crossing
    logic        ref_ph;               // next phase is reference

    // phase timing comes from the free counter
    dsps_phase_timer #(
        .PHASE_LEN (PHASE_LEN),
        .CNT_W     (CNT_W)
    ) u_timer (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .o_count   (),
        .o_wrap    (wrap)
    );

    // crossing seen only through the sampled comparator, so clock
    // feedthrough on the ramp between samples cannot stop the count
    assign crossed = (st_ff.comp != st_ff.pol);

    // next state
    always_comb begin
        nxt_st     = st_ff;
        nxt_st.vld = 1'b0;
        ref_ph     = 1'b0;
        // comparator sampled once per clock
        nxt_st.comp = i_comp;

        // phase sequence, equal lengths, advance on wrap
        if (wrap) begin
            case (st_ff.phase)
                DSPS_PH_ZERO:  nxt_st.phase = DSPS_PH_SIG;
                DSPS_PH_SIG:   nxt_st.phase = DSPS_PH_REF_A;
                DSPS_PH_REF_A: nxt_st.phase = DSPS_PH_REF_B;
                DSPS_PH_REF_B: nxt_st.phase = DSPS_PH_ZERO;
                default:       nxt_st.phase = DSPS_PH_ZERO;
            endcase
        end

        // sign of the ramp caught as the signal phase closes
        if (wrap && st_ff.phase == DSPS_PH_SIG) begin
            nxt_st.pol = st_ff.comp;
        end

        // result counter
        case (st_ff.phase)
            DSPS_PH_SIG: begin
                // armed for the reference window; no hold here
                if (wrap) begin
                    nxt_st.counting = 1'b1;
                    nxt_st.hold     = 1'b1;
                    nxt_st.cnt      = '0;
                end
            end
            DSPS_PH_REF_A,
            DSPS_PH_REF_B: begin
                if (st_ff.hold) begin
                    // first clock of phase three counts nothing,
                    // paying back the comparator flip-flop delay
                    nxt_st.hold = 1'b0;
                end else if (st_ff.counting && crossed) begin
                    // integrator back at zero: reading done
                    nxt_st.counting = 1'b0;
                    nxt_st.result   = st_ff.cnt;
                    nxt_st.over     = 1'b0;
                    nxt_st.vld      = 1'b1;
                end else if (st_ff.counting) begin
                    nxt_st.cnt = st_ff.cnt + RES_W'(1);
                end
                // window spans both reference phases only
                if (wrap && st_ff.phase == DSPS_PH_REF_B &&
                    st_ff.counting && !crossed) begin
                    // no crossing yet: decided in the phase-one hold
                    nxt_st.counting = 1'b0;
                    nxt_st.hold     = 1'b1;
                end
            end
            DSPS_PH_ZERO: begin
                if (st_ff.hold) begin
                    nxt_st.hold = 1'b0;
                    nxt_st.vld  = 1'b1;
                    if (crossed) begin
                        // ramp crossed on the last window clock; the
                        // flip-flop only shows it now, reading is valid
                        nxt_st.result = st_ff.cnt;
                        nxt_st.over   = 1'b0;
                    end else begin
                        // overload hold reads zero, not one
                        nxt_st.result = '0;
                        nxt_st.over   = 1'b1;
                    end
                end
            end
            default: begin
                nxt_st.counting = 1'b0;
            end
        endcase

        // switch decode from the phase about to run
        nxt_st.sw = '0;
        case (nxt_st.phase)
            DSPS_PH_ZERO: begin
                nxt_st.sw[DSPS_SW1] = 1'b1;
                nxt_st.sw[DSPS_SW2] = 1'b1;
                nxt_st.sw[DSPS_SW3] = 1'b1;
            end
            DSPS_PH_SIG: begin
                nxt_st.sw[DSPS_SW4] = 1'b1;
            end
            DSPS_PH_REF_A,
            DSPS_PH_REF_B: begin
                ref_ph = 1'b1;
            end
            default: begin
                ref_ph = 1'b0;
            end
        endcase
        // reference switch follows the polarity flip-flop
        if (ref_ph) begin
            if (nxt_st.pol) begin
                nxt_st.sw[DSPS_SW6] = 1'b1;
            end else begin
                nxt_st.sw[DSPS_SW5] = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            st_ff.phase    <= DSPS_PH_ZERO;
            st_ff.comp     <= 1'b0;
            st_ff.pol      <= DSPS_POL_RST;
            st_ff.counting <= 1'b0;
            st_ff.hold     <= 1'b0;
            st_ff.cnt      <= '0;
            st_ff.result   <= '0;
            st_ff.vld      <= 1'b0;
            st_ff.over     <= 1'b0;
            st_ff.sw       <= DSPS_SW_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flip-flops
    assign o_sw         = st_ff.sw;
    assign o_phase      = st_ff.phase;
    assign o_polarity   = st_ff.pol;
    assign o_result     = st_ff.result;
    assign o_result_vld = st_ff.vld;
    assign o_overrange  = st_ff.over;
endmodule : dsps_sequencer

/* verif/dsps_seq_properties.sv */
`timescale 1ns/10ps
// port checker: switch map, phase order, polarity and reading pulses
module dsps_seq_properties
    import dsps_pkg::*;
#(
    parameter int PHASE_LEN = 8,
    parameter int RES_W     = $clog2(PHASE_LEN) + 1
) (
    input wire logic             i_ref_clk,
    input wire logic             i_resetn,
    input wire logic             i_comp,
    input wire logic [5:0]       o_sw,
    input wire dsps_phase_t      o_phase,
    input wire logic             o_polarity,
    input wire logic [RES_W-1:0] o_result,
    input wire logic             o_result_vld,
    input wire logic             o_overrange
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    dsps_phase_t last_ff;  // phase one sample ago
    int          run_ff;   // samples spent in the old phase
    logic        seen_ff;  // first phase after reset is not timed
    // phase length tracker; reset length is not a full phase
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            last_ff <= DSPS_PH_ZERO;
            run_ff  <= 0;
            seen_ff <= 1'b0;
        end else begin
            last_ff <= o_phase;
            run_ff  <= (o_phase != last_ff) ? 1 : run_ff + 1;
            seen_ff <= seen_ff | (o_phase != last_ff);
        end
    end
    zero_switch_a: assert property (
        $past(i_resetn) && o_phase == DSPS_PH_ZERO |-> o_sw == 6'h07)
        else $error("auto-zero switch map wrong");
    sig_switch_a: assert property (
        o_phase == DSPS_PH_SIG |-> o_sw == 6'h08)
        else $error("signal switch map wrong");
    ref_switch_a: assert property (
        o_phase[1] |-> o_sw == (o_polarity ? 6'h20 : 6'h10))
        else $error("reference switch choice wrong");
    phase_step_a: assert property (
        o_phase != last_ff |-> o_phase == 2'(last_ff + 2'h1))
        else $error("phase out of order");
    phase_len_a: assert property (
        seen_ff && o_phase != last_ff |-> run_ff == PHASE_LEN)
        else $error("phase length wrong");
    vld_pulse_a: assert property (
        o_result_vld |=> !o_result_vld)
        else $error("reading pulse too long");
    over_zero_a: assert property (
        o_result_vld && o_overrange |-> o_result == '0
            && o_phase == DSPS_PH_ZERO)
        else $error("overload reading wrong");
    span_max_a: assert property (
        o_result_vld && !o_overrange |-> int'(o_result) < 2 * PHASE_LEN)
        else $error("reading beyond window");
    pol_hold_a: assert property (
        o_phase[1] && last_ff[1] |-> $stable(o_polarity))
        else $error("polarity moved in reference");
    pol_take_a: assert property (
        last_ff == DSPS_PH_SIG && o_phase == DSPS_PH_REF_A
            |-> o_polarity == $past(i_comp, 2))
        else $error("polarity not the sampled sign");
    cover property (o_result_vld && !o_overrange);
    cover property (o_result_vld && o_overrange);
    cover property (o_phase == DSPS_PH_REF_A && !o_polarity);
endmodule : dsps_seq_properties

/* verif/dsps_analog_model.sv */
`timescale 1ns/10ps
// integrator and comparator behind the switches, one step per clock
module dsps_analog_model
    import dsps_pkg::*;
#(
    parameter int REF_STEP = 4  // reference slope per clock
) (
    input  wire logic              i_ref_clk,
    input  wire logic [5:0]        i_sw,
    input  wire logic signed [7:0] i_vin,
    output logic                   o_comp
);
    int integ = 1;  // odd offset keeps the ramp off exact zero
    // switch set seen before the edge decides the slope
    always @(posedge i_ref_clk) begin
        if (i_sw[DSPS_SW3]) integ <= 1;
        else if (i_sw[DSPS_SW4]) integ <= integ + 2 * int'(i_vin);
        else if (i_sw[DSPS_SW6]) integ <= integ - 2 * REF_STEP;
        else if (i_sw[DSPS_SW5]) integ <= integ + 2 * REF_STEP;
    end
    assign o_comp = integ > 0;  // 1 = above zero
endmodule : dsps_analog_model

/* verif/testbench.sv */
`timescale 1ns/10ps
module testbench;
    import dsps_pkg::*;
    localparam int N = 8;  // short phase for simulation
    localparam int STEP = 4;
    localparam int RW = $clog2(N) + 1;
    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic comp, pol, vld, over;
    logic [5:0] sw;
    dsps_phase_t phase;
    logic [RW-1:0] res;
    logic signed [7:0] vin = 8'h00;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int corners[6] = '{0, 12, -12, -1, 7, -7};
    always #20 i_ref_clk = ~i_ref_clk;
    dsps_sequencer #(.PHASE_LEN(N)) i_dsps_sequencer (.i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn), .i_comp(comp), .o_sw(sw), .o_phase(phase),
        .o_polarity(pol), .o_result(res), .o_result_vld(vld),
        .o_overrange(over));
    dsps_analog_model #(.REF_STEP(STEP)) i_dsps_analog_model (
        .i_ref_clk(i_ref_clk), .i_sw(sw), .i_vin(vin), .o_comp(comp));
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    // reference clocks needed to bring the ramp back across zero
    function automatic int counts(int v);
        int s;
        s = 1 + 2 * N * v;
        if (s < 0) s = -s;
        return (s + 2 * STEP - 1) / (2 * STEP);
    endfunction : counts
    task automatic complete_run();
        if (n_errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    // input set in the signal phase, reading checked at its pulse
    task automatic convert(int v);
        int m;
        int k;
        k = 0;
        while (phase !== DSPS_PH_SIG && k < 5 * N) begin
            @(negedge i_ref_clk);
            k++;
        end
        vin = 8'(v);
        m = counts(v);
        k = 0;
        while (vld !== 1'b1 && k < 5 * N) begin
            @(negedge i_ref_clk);
            k++;
        end
        check("pulse", 16'(vld), 16'h0001);
        check("result", 16'(res), (m >= 2 * N) ? 16'h0000 : 16'(m));
        check("overrange", 16'(over), 16'(m >= 2 * N));
        check("polarity", 16'(pol), 16'(v >= 0));
        @(negedge i_ref_clk);
    endtask : convert
    // hang guard, about three times the planned run
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(89883));
        repeat (6) @(negedge i_ref_clk);
        i_resetn = 1'b1;
        foreach (corners[i]) convert(corners[i]);
        repeat (20) convert(int'($urandom_range(14)) - 7);
        repeat (N + 3) @(negedge i_ref_clk);
        i_resetn = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        i_resetn = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        check("zero map", 16'(sw), 16'h0007);
        convert(3);
        complete_run();
    end
endmodule : testbench
bind dsps_sequencer dsps_seq_properties #(.PHASE_LEN(PHASE_LEN),
    .RES_W(RES_W)) i_dsps_seq_properties (.i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn), .i_comp(i_comp), .o_sw(o_sw), .o_phase(o_phase),
    .o_polarity(o_polarity), .o_result(o_result),
    .o_result_vld(o_result_vld), .o_overrange(o_overrange));
